// ===== rtl/acrm_map.svh
// Purpose: offsets, field positions and reset values of the accelerometer register window
// Assumes: byte-wide registers addressed by an 8-bit register pointer
// Notes:   identity value is arbitrary
`ifndef ACRM_MAP_SVH
`define ACRM_MAP_SVH

`define ACRM_OFS_STATUS      8'h00
`define ACRM_OFS_X_HI        8'h01
`define ACRM_OFS_X_LO        8'h02
`define ACRM_OFS_Y_HI        8'h03
`define ACRM_OFS_Y_LO        8'h04
`define ACRM_OFS_Z_HI        8'h05
`define ACRM_OFS_Z_LO        8'h06
`define ACRM_OFS_RSV_A       8'h07
`define ACRM_OFS_RSV_B       8'h08
`define ACRM_OFS_BUF_SETUP   8'h09
`define ACRM_OFS_BUFFER_TRIGGER_CONFIG    8'h0A
`define ACRM_OFS_SYS_MODE    8'h0B
`define ACRM_OFS_INT_CAUSE   8'h0C
`define ACRM_OFS_IDENTITY    8'h0D
`define ACRM_OFS_RANGE_CFG   8'h0E
`define ACRM_OFS_HP_CUTOFF   8'h0F
`define ACRM_OFS_NEXT_BLOCK  8'h10

// Buffer mode field of buffer_setup, bits 7:6
`define ACRM_FMODE_MSB       7
`define ACRM_FMODE_LSB       6
// Range field of range_filter_config, bits 1:0
`define ACRM_RANGE_MSB       1
`define ACRM_RANGE_LSB       0
`define ACRM_RANGE_4G        2'h1

`define ACRM_RST_BUF_SETUP   8'h00
`define ACRM_RST_BUFFER_TRIGGER_CONFIG    8'h00
`define ACRM_RST_RANGE_CFG   8'h00
`define ACRM_RST_HP_CUTOFF   8'h00
`define ACRM_IDENTITY_VALUE  8'h5C // Arbitrary value, not a real part code

`endif

// ===== rtl/acrm_pkg.sv
// Purpose: types shared by the accelerometer register window
// Assumes: nothing beyond the map header
// Notes:   read pointer policy follows buffer mode and fast-read select
`default_nettype none
package acrm_pkg;
    typedef logic [7:0] acrm_byte_t;
    typedef enum logic [1:0]
    {
        ACRM_WALK_FULL  = 2'h0,
        ACRM_WALK_FAST  = 2'h1,
        ACRM_WALK_FIFO  = 2'h3
    } acrm_walk_e;
endpackage
`default_nettype wire

// ===== rtl/acrm_regs.sv
// Purpose: register window of a three-axis accelerometer, lower map 0x00 to 0x0F
// Assumes: serial framing decoded outside; one access strobe per byte
// Notes:   reads return data in the cycle after the strobe; pointer then advances
//
// Contract
// R1: Axis high-byte register holds sample bits 13:6 in bits 7:0.
// R2: Axis low-byte register holds sample bits 5:0 left-justified, low two zero.
// R3: Offset zero shows data-ready flags, or buffer status while buffering.
// R4: Normal burst steps all six output bytes, wraps from Z low to 0x00.
// R5: Buffer active: after X high byte the pointer returns to 0x01.
// R6: Fast-read, no buffer: high bytes only, wrap to 0x00 after Z high.
// R7: Fast-read: any low-byte read wraps the pointer to zero.
// R8: Host must not write reserved offsets 0x07 and 0x08.
// R9: Offset 0x0E holds range and filter enable, reads back as written.
// R10: Offset 0x0F holds pulse filter enables and high-pass cutoff select.
// R11: Noise-reduction active forces the effective range to four g.
// R12: Offsets 0x09 to 0x0F advance the pointer by one always.
// R13: Writes to read-only registers are ignored.
`include "acrm_map.svh"
`default_nettype none

module acrm_regs
(
    input  wire logic        clock,
    input  wire logic        arst_n,
    // Pointer load at the start of a transaction
    input  wire logic        addr_load,
    input  wire logic [7:0]  addr_value,
    // One strobe per byte transferred
    input  wire logic        rd_strobe,
    input  wire logic        wr_strobe,
    input  wire logic [7:0]  wr_data,
    // Control inputs from the primary control register
    input  wire logic        fast_read_select,
    input  wire logic        noise_reduction_select,
    // Sample path and status sources
    input  wire logic [13:0] sample_x,
    input  wire logic [13:0] sample_y,
    input  wire logic [13:0] sample_z,
    input  wire logic [7:0]  data_ready_flags,
    input  wire logic [5:0]  buffer_count,
    input  wire logic        buffer_overflow,
    input  wire logic        buffer_watermark,
    input  wire logic [7:0]  system_mode_state,
    input  wire logic [7:0]  interrupt_cause,
    output logic [7:0]       rd_data,
    output logic [7:0]       reg_pointer,
    output logic [7:0]       buffer_setup,
    output logic [7:0]       buffer_trigger_config,
    output logic [7:0]       range_filter_config,
    output logic [7:0]       highpass_cutoff_select,
    output logic [1:0]       effective_range
);

    logic [7:0] ptr_q;
    logic [7:0] ptr_d;
    logic [7:0] rd_data_q;
    logic [7:0] rd_data_d;
    logic [7:0] setup_q;
    logic [7:0] trig_q;
    logic [7:0] range_q;
    logic [7:0] hp_q;
    logic [1:0] eff_range_q;
    acrm_pkg::acrm_walk_e walk;

    function automatic logic [7:0] hi_byte(input logic [13:0] s);
        return s[13:6]; // R1
    endfunction

    function automatic logic [7:0] lo_byte(input logic [13:0] s);
        return {s[5:0], 2'h0}; // R2
    endfunction

    // Buffer mode wins over fast-read for the walk policy
    always_comb
    begin
        if (setup_q[`ACRM_FMODE_MSB:`ACRM_FMODE_LSB] != 2'h0)
            walk = acrm_pkg::ACRM_WALK_FIFO;
        else if (fast_read_select)
            walk = acrm_pkg::ACRM_WALK_FAST;
        else
            walk = acrm_pkg::ACRM_WALK_FULL;
    end

    // Next pointer after an access at the current pointer
    always_comb
    begin
        ptr_d = ptr_q + 8'h01; // R12
        unique case (ptr_q)
            `ACRM_OFS_X_HI:
            begin
                unique case (walk)
                    acrm_pkg::ACRM_WALK_FULL: ptr_d = `ACRM_OFS_X_LO; // R4
                    acrm_pkg::ACRM_WALK_FAST: ptr_d = `ACRM_OFS_Y_HI; // R6
                    acrm_pkg::ACRM_WALK_FIFO: ptr_d = `ACRM_OFS_X_HI; // R5
                    default:                  ptr_d = `ACRM_OFS_X_LO;
                endcase
            end
            `ACRM_OFS_Y_HI:
            begin
                if (walk == acrm_pkg::ACRM_WALK_FULL)
                    ptr_d = `ACRM_OFS_Y_LO; // R4
                else if (fast_read_select)
                    ptr_d = `ACRM_OFS_Z_HI; // R6
                else
                    ptr_d = `ACRM_OFS_Y_LO;
            end
            `ACRM_OFS_Z_HI:
            begin
                if (fast_read_select)
                    ptr_d = `ACRM_OFS_STATUS; // R6
                else
                    ptr_d = `ACRM_OFS_Z_LO;
            end
            `ACRM_OFS_X_LO, `ACRM_OFS_Y_LO:
            begin
                if (fast_read_select)
                    ptr_d = `ACRM_OFS_STATUS; // R7
                else
                    ptr_d = ptr_q + 8'h01; // R4
            end
            `ACRM_OFS_Z_LO:
                ptr_d = `ACRM_OFS_STATUS; // R4 R7
            `ACRM_OFS_STATUS:
                ptr_d = `ACRM_OFS_STATUS;
            default:
                ptr_d = ptr_q + 8'h01; // R12
        endcase
    end

    // Read mux
    always_comb
    begin
        unique case (ptr_q)
            `ACRM_OFS_STATUS:
            begin
                if (walk == acrm_pkg::ACRM_WALK_FIFO)
                    rd_data_d = {buffer_overflow, buffer_watermark, buffer_count}; // R3
                else
                    rd_data_d = data_ready_flags; // R3
            end
            `ACRM_OFS_X_HI:      rd_data_d = hi_byte(sample_x);
            `ACRM_OFS_X_LO:      rd_data_d = lo_byte(sample_x);
            `ACRM_OFS_Y_HI:      rd_data_d = hi_byte(sample_y);
            `ACRM_OFS_Y_LO:      rd_data_d = lo_byte(sample_y);
            `ACRM_OFS_Z_HI:      rd_data_d = hi_byte(sample_z);
            `ACRM_OFS_Z_LO:      rd_data_d = lo_byte(sample_z);
            `ACRM_OFS_BUF_SETUP: rd_data_d = setup_q;
            `ACRM_OFS_BUFFER_TRIGGER_CONFIG:  rd_data_d = trig_q;
            `ACRM_OFS_SYS_MODE:  rd_data_d = system_mode_state;
            `ACRM_OFS_INT_CAUSE: rd_data_d = interrupt_cause;
            `ACRM_OFS_IDENTITY:  rd_data_d = `ACRM_IDENTITY_VALUE;
            `ACRM_OFS_RANGE_CFG: rd_data_d = range_q; // R9
            `ACRM_OFS_HP_CUTOFF: rd_data_d = hp_q; // R10
            default:             rd_data_d = 8'h00;
        endcase
    end

    // Pointer: a load wins over stepping from a strobe in the same cycle
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            ptr_q <= 8'h00;
        else if (addr_load)
            ptr_q <= addr_value;
        else if (rd_strobe || wr_strobe)
            ptr_q <= ptr_d;
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            rd_data_q <= 8'h00;
        else if (rd_strobe)
            rd_data_q <= rd_data_d;
    end

    // Writable registers; read-only and reserved offsets drop the write
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            setup_q <= `ACRM_RST_BUF_SETUP;
            trig_q  <= `ACRM_RST_BUFFER_TRIGGER_CONFIG;
            range_q <= `ACRM_RST_RANGE_CFG;
            hp_q    <= `ACRM_RST_HP_CUTOFF;
        end
        else if (wr_strobe && !addr_load)
        begin
            unique case (ptr_q)
                `ACRM_OFS_BUF_SETUP: setup_q <= wr_data;
                `ACRM_OFS_BUFFER_TRIGGER_CONFIG:  trig_q  <= wr_data;
                `ACRM_OFS_RANGE_CFG: range_q <= wr_data; // R9
                `ACRM_OFS_HP_CUTOFF: hp_q    <= wr_data; // R10
                // Reserved 0x07/0x08 assumed never written by host; ignored anyway
                default:             ; // R13 R8
            endcase
        end
    end

    // Noise reduction pins range to four g regardless of the stored field
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            eff_range_q <= 2'h0;
        else if (noise_reduction_select)
            eff_range_q <= `ACRM_RANGE_4G; // R11
        else
            eff_range_q <= range_q[`ACRM_RANGE_MSB:`ACRM_RANGE_LSB];
    end

    assign rd_data                = rd_data_q;
    assign reg_pointer            = ptr_q;
    assign buffer_setup           = setup_q;
    assign buffer_trigger_config  = trig_q;
    assign range_filter_config    = range_q;
    assign highpass_cutoff_select = hp_q;
    assign effective_range        = eff_range_q;

endmodule // acrm_regs
`default_nettype wire

// ===== dv/acrm_regs_checker.sv
// Purpose: port checks on the register window
// Assumes: strobes in a load cycle neither step the pointer nor write; read data still latches
// Notes:   pointer rules cover bytes taken without a load
`default_nettype none
module acrm_regs_checker
(
    input wire logic        clock,
    input wire logic        arst_n,
    input wire logic        addr_load,
    input wire logic        rd_strobe,
    input wire logic        wr_strobe,
    input wire logic        fast_read_select,
    input wire logic        noise_reduction_select,
    input wire logic [13:0] sample_x,
    input wire logic [7:0]  rd_data,
    input wire logic [7:0]  reg_pointer,
    input wire logic [7:0]  buffer_setup,
    input wire logic [1:0]  effective_range
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);
    logic       rd;
    logic [1:0] m;
    assign rd = rd_strobe && !addr_load;
    assign m = buffer_setup[7:6];
    x_high_a: assert property (rd && reg_pointer == 8'h01 |=>
        {rd_data, 6'h00} == ($past(sample_x) & 14'h3FC0)) else $error("x high byte");
    x_low_a: assert property (rd && reg_pointer == 8'h02 |=>
        {6'h00, rd_data} == (($past(sample_x) << 2) & 14'h00FF)) else $error("x low byte");
    plain_wrap_a: assert property (rd && m == 2'h0 && !fast_read_select &&
        reg_pointer == 8'h06 |=> reg_pointer == 8'h00) else $error("plain wrap");
    buffer_hold_a: assert property (rd && m != 2'h0 && reg_pointer == 8'h01 |=>
        reg_pointer == 8'h01) else $error("buffer hold");
    fast_skip_a: assert property (rd && m == 2'h0 && fast_read_select &&
        reg_pointer == 8'h03 |=> reg_pointer == 8'h05) else $error("fast skip");
    fast_low_a: assert property (rd && fast_read_select &&
        reg_pointer inside {8'h02, 8'h04, 8'h06} |=> reg_pointer == 8'h00) else $error("fast low");
    upper_step_a: assert property ((rd || wr_strobe && !addr_load) &&
        reg_pointer inside {[8'h09:8'h0F]} |=> reg_pointer == $past(reg_pointer) + 8'h01)
        else $error("upper step");
    noise_range_a: assert property (noise_reduction_select |=>
        effective_range == 2'h1) else $error("noise range");
    cover property (rd && m != 2'h0 && reg_pointer == 8'h01);
    cover property (rd && fast_read_select && reg_pointer == 8'h05);
    cover property (wr_strobe && !addr_load && reg_pointer == 8'h0F);
endmodule // acrm_regs_checker
bind acrm_regs acrm_regs_checker i_acrm_regs_checker (.clock, .arst_n, .addr_load,
    .rd_strobe, .wr_strobe, .fast_read_select, .noise_reduction_select, .sample_x,
    .rd_data, .reg_pointer, .buffer_setup, .effective_range);
`default_nettype wire

// ===== dv/acrm_host.sv
// Purpose: host side of the register window
// Assumes: tasks start just after a rising edge
// Notes:   released fields flip so stale values never pass
`default_nettype none
module acrm_host
(
    input  wire logic       clock,
    input  wire logic [7:0] rd_data,
    output var logic        addr_load = 1'b0,
    output var logic [7:0]  addr_value = 8'h00,
    output var logic        rd_strobe = 1'b0,
    output var logic        wr_strobe = 1'b0,
    output var logic [7:0]  wr_data = 8'h00
);
    timeunit 1ns;
    timeprecision 100ps;
    // Callers never aim writes at 0x07 or 0x08
    task automatic xfer(input logic [7:0] a, input int n, input logic w,
        input logic [7:0] d, output logic [7:0] q[$]);
        addr_load = 1'b1;
        addr_value = a;
        @(posedge clock);
        #1;
        addr_load = 1'b0;
        addr_value = ~a;
        rd_strobe = !w;
        wr_strobe = w;
        wr_data = w ? d : ~wr_data;
        repeat (n)
        begin
            @(posedge clock);
            #1;
            q.push_back(rd_data);
        end
        rd_strobe = 1'b0;
        wr_strobe = 1'b0;
        wr_data = ~wr_data;
    endtask
endmodule // acrm_host
`default_nettype wire

// ===== dv/test_acrm_regs.sv
// Purpose: bench for the register window
// Assumes: status, mode and cause sources driven from the random stream
// Notes:   bursts of six cover every mode and fast setting
`include "acrm_map.svh"
`default_nettype none
module test_acrm_regs;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clock, arst_n, fast_read_select, noise_reduction_select;
    logic        addr_load, rd_strobe, wr_strobe;
    logic [7:0]  addr_value, wr_data, data_ready_flags, rd_data, reg_pointer, range_filter_config, p;
    logic [7:0]  system_mode_state, interrupt_cause, buffer_setup, buffer_trigger_config;
    logic [7:0]  highpass_cutoff_select;
    logic [5:0]  buffer_count;
    logic        buffer_overflow, buffer_watermark;
    logic [7:0]  t [7];
    logic [7:0]  q[$];
    logic [13:0] sample_x, sample_y, sample_z;
    logic [1:0]  effective_range;
    logic [15:0] r = 16'hA696;
    int          failures = 0, check_count = 0;
    acrm_regs i_acrm_regs
    (
        .clock, .arst_n, .addr_load, .addr_value, .rd_strobe, .wr_strobe, .wr_data,
        .fast_read_select, .noise_reduction_select, .sample_x, .sample_y, .sample_z,
        .data_ready_flags, .buffer_count, .buffer_overflow,
        .buffer_watermark, .system_mode_state, .interrupt_cause,
        .rd_data, .reg_pointer, .buffer_setup, .buffer_trigger_config,
        .range_filter_config, .highpass_cutoff_select, .effective_range
    );
    acrm_host i_acrm_host
    (
        .clock, .rd_data, .addr_load, .addr_value, .rd_strobe, .wr_strobe, .wr_data
    );
    function automatic logic [15:0] step(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    function automatic logic [7:0] nxt(input logic [1:0] m, input logic f, input logic [7:0] a);
        if (a == 8'h00 || m != 2'h0 && a == 8'h01)
            return a;
        if (f)
            return a inside {8'h01, 8'h03} ? a + 8'h02 : 8'h00;
        return a == 8'h06 ? 8'h00 : a + 8'h01;
    endfunction
    task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e)
        begin
            failures++;
            $display("BAD %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic print_verdict;
        if (failures == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    initial
    begin
        #5000;
        failures++;
        print_verdict;
    end
    initial
    begin
        arst_n = 1'b0;
        fast_read_select = 1'b0;
        noise_reduction_select = 1'b0;
        data_ready_flags = 8'h00;
        {sample_x, sample_y, sample_z} = '0;
        {buffer_overflow, buffer_watermark, buffer_count} = 8'h00;
        system_mode_state = 8'h00;
        interrupt_cause = 8'h00;
        repeat (10) @(posedge clock);
        #1;
        arst_n = 1'b1;
        chk("range reset", 8'h00, range_filter_config);
        // Range code 2 so the forced 4 g code shows
        i_acrm_host.xfer(8'h0D, 3, 1'b1, {r[7:2], 2'h2}, q);
        chk("cutoff out", {r[7:2], 2'h2}, highpass_cutoff_select);
        noise_reduction_select = 1'b1;
        system_mode_state = r[15:8];
        interrupt_cause = ~r[15:8];
        i_acrm_host.xfer(8'h0B, 5, 1'b0, 8'h00, q);
        chk("mode state", r[15:8], q[0]);
        chk("int cause", ~r[15:8], q[1]);
        chk("identity", `ACRM_IDENTITY_VALUE, q[2]);
        chk("range cfg", {r[7:2], 2'h2}, q[3]);
        chk("cutoff", {r[7:2], 2'h2}, q[4]);
        chk("range used", 8'h01, {6'h00, effective_range});
        noise_reduction_select = 1'b0;
        @(posedge clock);
        #1;
        chk("range free", 8'h02, {6'h00, effective_range});
        // Mid-run reset must clear stored settings and the pointer
        arst_n = 1'b0;
        repeat (2) @(posedge clock);
        #1;
        arst_n = 1'b1;
        chk("pointer reset", 8'h00, reg_pointer);
        chk("range cleared", 8'h00, range_filter_config);
        i_acrm_host.xfer(8'h0E, 1, 1'b0, 8'h00, q);
        chk("range reread", 8'h00, q[0]);
        for (int i = 0; i < 16; i++)
        begin
            r = step(r);
            fast_read_select = i[1];
            sample_x = r[13:0];
            sample_y = ~r[13:0];
            sample_z = {r[6:0], r[13:7]};
            data_ready_flags = r[15:8];
            {buffer_overflow, buffer_watermark, buffer_count} = r[11:4];
            t = '{i[3:2] == 2'h0 ? data_ready_flags : r[11:4], sample_x[13:6],
                {sample_x[5:0], 2'h0}, sample_y[13:6], {sample_y[5:0], 2'h0},
                sample_z[13:6], {sample_z[5:0], 2'h0}};
            i_acrm_host.xfer(8'h09, 2, 1'b1, {i[3:2], r[5:0]}, q);
            chk("buffer setup", {i[3:2], r[5:0]}, buffer_setup);
            chk("trigger cfg", {i[3:2], r[5:0]}, buffer_trigger_config);
            p = {6'h00, i[0], ~i[0]};
            i_acrm_host.xfer(p, 6, 1'b0, 8'h00, q);
            foreach (q[k])
            begin
                chk("burst byte", t[p], q[k]);
                p = nxt(i[3:2], i[1], p);
            end
            chk("pointer", p, reg_pointer);
        end
        print_verdict;
    end
endmodule // test_acrm_regs
`default_nettype wire
